// ===== rtl/fsie_pkg.sv
// Purpose: shared constants and types of the fault status / interrupt enable block
// Assumes: 16-bit registers at byte-free offsets on a plain register port
// Notes:   two-bit enable fields read 0h/2h and take 1h/3h on write
package fsie_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int N_SUP  = 4;
  localparam int N_EN   = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_LED_FAULT_IRQ_ENABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_FAULT_STATUS  = 8'h0E;
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_FAULT_MASK    = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EVENT_STATUS     = 8'h22;

  // reset values
  localparam logic [DATA_W-1:0] LED_FAULT_IRQ_ENABLE_RST = 16'h00AA;
  localparam logic [DATA_W-1:0] SUPPLY_FAULT_STATUS_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] SUPPLY_FAULT_MASK_RST    = 16'hAA00;
  localparam logic [DATA_W-1:0] IRQ_EVENT_STATUS_RST     = 16'h0000;

  // two-bit enable field encodings
  localparam logic [1:0] EN_RD_ON  = 2'h2;
  localparam logic [1:0] EN_RD_OFF = 2'h0;
  localparam logic [1:0] EN_WR_OFF = 2'h1;
  localparam logic [1:0] EN_WR_ON  = 2'h3;

  // enable field positions: 0 led_fault_irq_gate, 1 bad_string_cfg_irq_gate, 2 bus timeout, 3 global
  localparam int EN_LSB [0:N_EN-1] = '{0, 2, 4, 6};
  localparam int EN_GLOBAL     = 3;
  localparam int RSVD_LSB      = 8;
  localparam int RSVD_W        = 8;

  // supply flag positions: 0 crc, 1 sync loss, 2 pump, 3 pump cap; ack bit sits one below
  localparam int SUP_FLAG_POS [0:N_SUP-1] = '{15, 13, 11, 9};

  typedef struct packed {
    logic crc_err;
    logic sync_loss;
    logic pump_fault;
    logic pump_cap_missing;
    logic bus_timeout;
    logic bad_string_cfg;
    logic led_fault;
  } fsie_det_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fsie_bus_req_t;

endpackage

// ===== rtl/fsie_fault_irq.sv
// Purpose: fault status latching, interrupt enable fields and interrupt output
// Assumes: detectors and register port are synchronous to sys_clk
// Notes on behaviour
// (R1) each enable field reads 0h when disabled and 2h when enabled
// (R2) writing 1h disables a field, 3h enables it; other codes change nothing
// (R3) global enable field resets enabled; reserved upper byte resets to zero
// (R4) bus timeout interrupt enable field exists and resets enabled
// (R5) invalid string configuration enable field exists and resets enabled
// (R6) bits 1-0 gate led open/short faults and reset enabled
// (R7) supply fault status sits at 0Eh and resets to all zero
// (R8) writing one to flag and its ack together clears flag and interrupt
// (R9) bit 15 shows a recorded crc error fault
// (R10) bit 14 is the crc error ack companion
// (R11) bit 13 shows a missing boost sync fault
// (R12) bit 12 is the sync loss ack companion
// (R13) bit 11 shows a charge pump fault
// (R14) bit 10 is the charge pump ack companion
// (R15) bit 9 shows a missing charge pump capacitor fault
// (R16) bit 8 is the pump capacitor ack companion
// (R17) led interrupt enable register sits at 0Ch
// (R18) flags latch on detection; irq while an enabled flag is set
// (R19) writing only a flag or only its ack leaves the flag unchanged
`timescale 1ns/100ps

module fsie_fault_irq
(
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire fsie_pkg::fsie_bus_req_t       bus_req,
  output logic [fsie_pkg::DATA_W-1:0]        rd_data,
  output logic                               rd_valid,
  input  wire fsie_pkg::fsie_det_t           det,
  output logic                               irq
);

  // state
  logic [fsie_pkg::N_EN-1:0]    en;
  logic [fsie_pkg::N_EN-1:0]    next_en;
  logic [fsie_pkg::RSVD_W-1:0]  rsvd;
  logic [fsie_pkg::RSVD_W-1:0]  next_rsvd;
  logic [fsie_pkg::N_SUP-1:0]   sup_flag;
  logic [fsie_pkg::N_SUP-1:0]   next_sup_flag;
  logic [fsie_pkg::N_SUP-1:0]   sup_mask;
  logic [fsie_pkg::N_SUP-1:0]   next_sup_mask;
  logic [fsie_pkg::N_EN-2:0]    evt_flag;
  logic [fsie_pkg::N_EN-2:0]    next_evt_flag;
  logic                         next_irq;
  logic [fsie_pkg::DATA_W-1:0]  next_rd_data;

  // detector fan-out into indexed vectors
  wire [fsie_pkg::N_SUP-1:0]  sup_det;
  wire [fsie_pkg::N_EN-2:0]   evt_det;
  assign sup_det = {det.pump_cap_missing, det.pump_fault, det.sync_loss, det.crc_err};
  assign evt_det = {det.bus_timeout, det.bad_string_cfg, det.led_fault};

  // address decode
  // full compare, so no alias of a mapped offset can flip a gate
  wire hit_en   = bus_req.addr == fsie_pkg::ADDR_LED_FAULT_IRQ_ENABLE; // R17
  wire hit_sup  = bus_req.addr == fsie_pkg::ADDR_SUPPLY_FAULT_STATUS;  // R7
  wire hit_mask = bus_req.addr == fsie_pkg::ADDR_SUPPLY_FAULT_MASK;
  wire hit_evt  = bus_req.addr == fsie_pkg::ADDR_IRQ_EVENT_STATUS;
  wire wr_en    = bus_req.wr && hit_en;
  wire wr_sup   = bus_req.wr && hit_sup;
  wire wr_mask  = bus_req.wr && hit_mask;
  wire wr_evt   = bus_req.wr && hit_evt;

  // readback images
  wire [fsie_pkg::DATA_W-1:0] en_image;
  wire [fsie_pkg::DATA_W-1:0] sup_image;
  wire [fsie_pkg::DATA_W-1:0] mask_image;
  wire [fsie_pkg::DATA_W-1:0] evt_image;

  // upper byte of the enable register is plain storage
  assign next_rsvd = wr_en ? bus_req.wdata[fsie_pkg::RSVD_LSB +: fsie_pkg::RSVD_W] : rsvd; // R3
  assign en_image[fsie_pkg::RSVD_LSB +: fsie_pkg::RSVD_W] = rsvd;

  genvar gi;
  // enable fields: one bit of state each, two bits on the bus
  generate
    for (gi = 0; gi < fsie_pkg::N_EN; gi++)
    begin : g_en
      wire [1:0] code = bus_req.wdata[fsie_pkg::EN_LSB[gi] +: 2];
      // codes 0h and 2h are ignored so a read-modify-write never flips a field
      assign next_en[gi] = (wr_en && code == fsie_pkg::EN_WR_ON)  ? 1'b1 :     // R2
                           (wr_en && code == fsie_pkg::EN_WR_OFF) ? 1'b0 :     // R2
                           en[gi];
      assign en_image[fsie_pkg::EN_LSB[gi] +: 2] = en[gi] ? fsie_pkg::EN_RD_ON
                                                          : fsie_pkg::EN_RD_OFF; // R1
    end
  endgenerate

  // supply fault flags with paired ack bits
  generate
    for (gi = 0; gi < fsie_pkg::N_SUP; gi++)
    begin : g_sup
      localparam int FP = fsie_pkg::SUP_FLAG_POS[gi];
      // both bits must be one; a lone flag or ack write is ignored
      wire pair_clr = wr_sup && bus_req.wdata[FP] && bus_req.wdata[FP-1];      // R8 R19
      // a detection in the clearing cycle wins, so no fault is lost
      assign next_sup_flag[gi] = sup_det[gi] || (sup_flag[gi] && !pair_clr);  // R18
      assign next_sup_mask[gi] = wr_mask ? bus_req.wdata[FP] : sup_mask[gi];
      assign sup_image[FP]     = sup_flag[gi];                                 // R9 R11 R13 R15
      assign sup_image[FP-1]   = 1'b0;                                         // R10 R12 R14 R16
      assign mask_image[FP]    = sup_mask[gi];
      assign mask_image[FP-1]  = 1'b0;
    end
  endgenerate

  // supply-side events that this block does not hold read as zero
  assign sup_image[7:0]  = 8'h00;
  assign mask_image[7:0] = 8'h00;

  // led-side event flags, write one to clear, at the same bit as their enable field
  // held here only so the led-side gates have something to gate
  generate
    for (gi = 0; gi < fsie_pkg::N_EN - 1; gi++)
    begin : g_evt
      wire w1c = wr_evt && bus_req.wdata[fsie_pkg::EN_LSB[gi]];
      assign next_evt_flag[gi] = evt_det[gi] || (evt_flag[gi] && !w1c);        // R18
      assign evt_image[fsie_pkg::EN_LSB[gi]]     = evt_flag[gi];
      assign evt_image[fsie_pkg::EN_LSB[gi] + 1] = 1'b0;
    end
  endgenerate
  assign evt_image[fsie_pkg::DATA_W-1:fsie_pkg::EN_LSB[fsie_pkg::EN_GLOBAL]] = '0;

  // interrupt: global gate over masked supply flags and enabled led-side flags
  // irq is registered, so it lags its flag by one cycle but never glitches
  wire sup_pending = |(sup_flag & sup_mask);
  wire evt_pending = |(evt_flag & en[fsie_pkg::N_EN-2:0]);                     // R6
  assign next_irq  = en[fsie_pkg::EN_GLOBAL] && (sup_pending || evt_pending);  // R18

  // read mux; unmapped addresses return zero
  // zero outside a read cycle keeps stale data off the bus
  assign next_rd_data = !bus_req.rd ? '0 :
                        hit_en      ? en_image   :
                        hit_sup     ? sup_image  :
                        hit_mask    ? mask_image :
                        hit_evt     ? evt_image  : '0;

  // enable register and reserved byte
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en   <= {fsie_pkg::N_EN{1'b1}};                                          // R3 R4 R5 R6
      rsvd <= fsie_pkg::LED_FAULT_IRQ_ENABLE_RST[fsie_pkg::RSVD_LSB +: fsie_pkg::RSVD_W];
    end
    else
    begin
      en   <= next_en;
      rsvd <= next_rsvd;
    end
  end

  // fault flags and mask
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sup_flag <= '0;                                                          // R7
      sup_mask <= {fsie_pkg::N_SUP{1'b1}};
      evt_flag <= '0;
    end
    else
    begin
      sup_flag <= next_sup_flag;
      sup_mask <= next_sup_mask;
      evt_flag <= next_evt_flag;
    end
  end

  // registered outputs; read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      rd_data  <= next_rd_data;
      rd_valid <= bus_req.rd;
      irq      <= next_irq;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  wire rd_en_reg  = bus_req.rd && hit_en;
  wire rd_sup_reg = bus_req.rd && hit_sup;
  wire [fsie_pkg::RSVD_W-1:0] wr_rsvd_field = bus_req.wdata[fsie_pkg::RSVD_LSB +: fsie_pkg::RSVD_W];

  AST_EN_READBACK: // R1
    assert property (rd_en_reg |=> rd_data[1:0] == {$past(en[0]), 1'b0}
                                 && rd_data[7:6] == {$past(en[3]), 1'b0})
    else $error("enable field readback not 0h/2h of its state");

  AST_EN_WRITE: // R2
    assert property (wr_en && bus_req.wdata[3:2] == fsie_pkg::EN_RD_ON && en[1] |=> en[1])
    else $error("enable field lost on a 2h write");

  AST_EN_DISABLE: // R2
    assert property (wr_en && bus_req.wdata[5:4] == 2'h1 |=> !en[2] ##1 (en[2] == $past(next_en[2])))
    else $error("enable field not disabled by 1h");

  AST_RESET_VALUES: // R3
    assert property ($rose(rst_n) |-> en == 4'hF && rsvd == 8'h00 && sup_flag == 4'h0 && !irq)
    else $error("reset values wrong");

  AST_STATUS_RESET_READ: // R7
    assert property ($rose(rst_n) && rd_sup_reg |=> rd_data == 16'h0000)
    else $error("supply status not zero after reset");

  AST_PAIR_CLEAR: // R8
    assert property (wr_sup && bus_req.wdata[15:14] == 2'h3 && det == '0
                     && !(|sup_flag[3:1]) && !(|evt_flag) |=> !sup_flag[0] ##1 !irq)
    else $error("pair write did not clear flag and interrupt");

  AST_FLAG_SET: // R9
    assert property (det.crc_err ##1 rd_sup_reg |=> rd_data[15] && !rd_data[14])
    else $error("crc fault not shown at bit 15");

  AST_ACK_READS_ZERO: // R10
    assert property (rd_sup_reg |=> rd_data[14] == 1'b0 && rd_data[12] == 1'b0
                                 && rd_data[10] == 1'b0 && rd_data[8] == 1'b0)
    else $error("ack bit reads nonzero");

  AST_SYNC_SET: // R11
    assert property (det.sync_loss |=> sup_flag[1] [*2] or (sup_flag[1] ##1 !sup_flag[1]))
    else $error("sync loss not latched");

  AST_PUMP_HOLD: // R13
    assert property (sup_flag[2] && !(wr_sup && bus_req.wdata[11] && bus_req.wdata[10]) |=> sup_flag[2])
    else $error("pump fault flag dropped without pair write");

  AST_CAP_SET: // R15
    assert property (det.pump_cap_missing ##1 rd_sup_reg |=> rd_data[9])
    else $error("pump cap fault not shown at bit 9");

  AST_IRQ_FOLLOWS: // R18
    assert property (det.led_fault && en[0] && en[3] && !wr_en |-> ##2 irq)
    else $error("irq did not follow enabled led fault");

  AST_IRQ_GLOBAL_OFF: // R18
    assert property (!en[3] |=> !irq)
    else $error("irq high with global enable off");

  AST_HALF_WRITE: // R19
    assert property (wr_sup && (bus_req.wdata[13] ^ bus_req.wdata[12]) && sup_flag[1] |=> sup_flag[1])
    else $error("lone flag or ack write cleared a fault");

  // bus port timing; wr and rd never come together, so read checks ignore writes
  AST_RD_VALID_PULSE:
    assert property (bus_req.rd |=> rd_valid)
    else $error("read strobe not answered in the next cycle");

  AST_RD_IDLE_ZERO:
    assert property (!bus_req.rd |=> !rd_valid && rd_data == '0)
    else $error("read data or valid outside the answer cycle");

  AST_UNMAPPED_READ:
    assert property (bus_req.rd && !(hit_en || hit_sup || hit_mask || hit_evt) |=> rd_data == '0)
    else $error("unmapped read returned nonzero");

  // enable field writes and readback
  AST_LED_GATE_ON: // R6
    assert property (wr_en && bus_req.wdata[1:0] == fsie_pkg::EN_WR_ON |=> en[0])
    else $error("led gate not enabled by 3h");

  AST_LED_GATE_OFF: // R6
    assert property (wr_en && bus_req.wdata[1:0] == fsie_pkg::EN_WR_OFF |=> !en[0])
    else $error("led gate not disabled by 1h");

  AST_STRING_GATE_OFF: // R5
    assert property (wr_en && bus_req.wdata[3:2] == fsie_pkg::EN_WR_OFF |=> !en[1])
    else $error("string config gate not disabled by 1h");

  AST_TIMEOUT_GATE_ON: // R4
    assert property (wr_en && bus_req.wdata[5:4] == fsie_pkg::EN_WR_ON |=> en[2])
    else $error("bus timeout gate not enabled by 3h");

  AST_GLOBAL_GATE_OFF: // R3
    assert property (wr_en && bus_req.wdata[7:6] == fsie_pkg::EN_WR_OFF |=> !en[3])
    else $error("global gate not disabled by 1h");

  AST_GLOBAL_GATE_ON: // R3
    assert property (wr_en && bus_req.wdata[7:6] == fsie_pkg::EN_WR_ON |=> en[3])
    else $error("global gate not enabled by 3h");

  AST_EN_IDLE_HOLD: // R2
    assert property (!wr_en |=> en == $past(en))
    else $error("enable field changed without a write");

  AST_RSVD_WRITE: // R3
    assert property (wr_en |=> rsvd == $past(wr_rsvd_field))
    else $error("reserved byte not stored");

  AST_EN_READ_MID: // R4 R5
    assert property (rd_en_reg |=> rd_data[5:2] == {$past(en[2]), 1'b0, $past(en[1]), 1'b0})
    else $error("string or timeout field readback wrong");

  AST_EN_READ_RSVD: // R3
    assert property (rd_en_reg |=> rd_data[15:8] == $past(rsvd))
    else $error("reserved byte readback wrong");

  // supply flags; a same-cycle detection wins, so the clear checks exclude it
  AST_CRC_CLEAR: // R10
    assert property (wr_sup && bus_req.wdata[15:14] == 2'h3 && !det.crc_err |=> !sup_flag[0])
    else $error("crc pair write did not clear");

  AST_SYNC_CLEAR: // R12
    assert property (wr_sup && bus_req.wdata[13:12] == 2'h3 && !det.sync_loss |=> !sup_flag[1])
    else $error("sync loss pair write did not clear");

  AST_PUMP_CLEAR: // R14
    assert property (wr_sup && bus_req.wdata[11:10] == 2'h3 && !det.pump_fault |=> !sup_flag[2])
    else $error("pump fault pair write did not clear");

  AST_CAP_CLEAR: // R16
    assert property (wr_sup && bus_req.wdata[9:8] == 2'h3 && !det.pump_cap_missing |=> !sup_flag[3])
    else $error("pump cap pair write did not clear");

  AST_PUMP_SET: // R13
    assert property (det.pump_fault |=> sup_flag[2])
    else $error("pump fault not latched");

  AST_CAP_HOLD: // R15
    assert property (sup_flag[3] && !(wr_sup && bus_req.wdata[9] && bus_req.wdata[8]) |=> sup_flag[3])
    else $error("pump cap flag dropped without pair write");

  AST_STATUS_LOW_READ: // R7
    assert property (rd_sup_reg |=> rd_data[7:0] == 8'h00)
    else $error("supply status low byte nonzero");

  AST_STATUS_READ: // R9 R11 R13 R15
    assert property (rd_sup_reg |=> rd_data[15] == $past(sup_flag[0]) && rd_data[13] == $past(sup_flag[1])
                                 && rd_data[11] == $past(sup_flag[2]) && rd_data[9] == $past(sup_flag[3]))
    else $error("supply flag readback wrong");

  // led-side flags and the interrupt level
  AST_EVT_HOLD: // R18
    assert property (evt_flag[0] && !(wr_evt && bus_req.wdata[0]) |=> evt_flag[0])
    else $error("led fault flag dropped without a clear");

  AST_EVT_CLEAR: // R18
    assert property (wr_evt && bus_req.wdata[2] && !det.bad_string_cfg |=> !evt_flag[1])
    else $error("string config flag not cleared");

  AST_IRQ_SUPPLY: // R18
    assert property (sup_flag[0] && sup_mask[0] && en[3] |=> irq)
    else $error("irq low with an enabled supply flag");

  AST_IRQ_IDLE: // R18
    assert property (sup_flag == '0 && evt_flag == '0 |=> !irq)
    else $error("irq high with no flag set");

  CVR_PAIR_CLEAR:
    cover property (sup_flag[0] ##1 wr_sup && bus_req.wdata[15:14] == 2'h3 ##1 !sup_flag[0]);

  CVR_IRQ_RISE:
    cover property (!irq ##1 irq);

  CVR_GLOBAL_DISABLE:
    cover property (irq ##1 wr_en && bus_req.wdata[7:6] == 2'h1 ##2 !irq);

  CVR_SET_WINS:
    cover property (det.pump_fault && wr_sup && bus_req.wdata[11:10] == 2'h3 ##1 sup_flag[2]);

  CVR_EVT_CLEAR:
    cover property (evt_flag[0] ##1 wr_evt && bus_req.wdata[0] ##1 !evt_flag[0]);

endmodule

// ===== tb/fsie_host.sv
// Purpose: host side model of the register port
// Assumes: strobes are one cycle wide and launched just after a rising edge
// Notes:   address and data stay parked between transfers; read data exist one cycle only
`timescale 1ns/100ps

module fsie_host
(
  input  wire logic                         sys_clk,
  input  wire logic [fsie_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                         rd_valid,
  output fsie_pkg::fsie_bus_req_t           bus_req
);
  initial bus_req = '0;

  // write strobe then an idle cycle, so no strobe is raised in the step it fell
  task automatic wr(input logic [fsie_pkg::ADDR_W-1:0] a, input logic [15:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge sys_clk);
    bus_req.wr <= 1'h0;
    @(posedge sys_clk);
  endtask

  // answer is caught inside the single cycle after the strobe
  task automatic rd(input logic [fsie_pkg::ADDR_W-1:0] a, output logic [15:0] d, output logic v);
    bus_req <= '{addr: a, wdata: bus_req.wdata, wr: 1'h0, rd: 1'h1};
    @(posedge sys_clk);
    bus_req.rd <= 1'h0;
    #1;
    d = rd_data;
    v = rd_valid;
    @(posedge sys_clk);
  endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the fault status and interrupt enable block
// Assumes: all register traffic goes through the host model; detectors driven here
// Notes:   irq is judged one step after an edge, except the checks right after a host task, which read it in the edge's own step
`timescale 1ns/100ps

module tb_top;
  typedef struct {logic w; logic [7:0] a; logic [15:0] wd; logic [15:0] ex;} fsie_row_t;
  logic                     sys_clk   = 1'h0;
  logic                     rst_n     = 1'h0;
  fsie_pkg::fsie_det_t      det       = '0;
  fsie_pkg::fsie_bus_req_t  bus_req;
  logic [15:0]              rd_data;
  logic                     rd_valid;
  logic                     irq;
  logic [15:0]              d;
  logic                     v;
  int                       p;
  int                       err_count = 0;
  int                       checks    = 0;
  // write flag, address, write data, expected read-back
  fsie_row_t rows [0:10] = '{'{1'h0, 8'h0C, 16'h0000, 16'h00AA}, '{1'h0, 8'h0E, 16'h0000, 16'h0000},
    '{1'h0, 8'h20, 16'h0000, 16'hAA00}, '{1'h0, 8'h22, 16'h0000, 16'h0000},
    '{1'h1, 8'h0C, 16'h0055, 16'h0000}, '{1'h1, 8'h0C, 16'h00FF, 16'h00AA},
    '{1'h1, 8'h0C, 16'h00AA, 16'h00AA}, '{1'h1, 8'h0C, 16'h1234, 16'h12A2},
    '{1'h1, 8'h40, 16'hFFFF, 16'h0000}, '{1'h1, 8'h0C, 16'h00FF, 16'h00AA},
    '{1'h1, 8'h0E, 16'hFFFF, 16'h0000}};

  always #2 sys_clk = ~sys_clk;

  fsie_fault_irq dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
                      .rd_valid(rd_valid), .det(det), .irq(irq));
  fsie_host host (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid), .bus_req(bus_req));

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for the interrupt level; running out ends the run
  task automatic wait_irq(input logic val);
    logic seen;
    seen = 1'h0;
    for (int n = 0; n < 4 && !seen; n++)
    begin
      @(posedge sys_clk);
      #1;
      seen = (irq === val);
    end
    // back onto a rising edge so the next request launches there
    @(posedge sys_clk);
    chk({15'h0, seen}, 16'h0001);
    if (!seen)
      stop_test();
  endtask

  // one-cycle detector event
  task automatic pulse(input logic [6:0] m);
    det <= m;
    @(posedge sys_clk);
    det <= '0;
  endtask

  // watchdog against a hang anywhere in the sequence
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("CHECK FAILED t=%0t watchdog got=%h exp=%h", $time, 1'h1, 1'h0);
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    foreach (rows[i])
    begin
      if (rows[i].w)
        host.wr(rows[i].a, rows[i].wd);
      host.rd(rows[i].a, d, v);
      chk(d, rows[i].ex);
      chk({15'h0, v}, 16'h0001);
    end
    $display("test register table done");
    // each supply fault: latch, half-writes ignored, paired write clears
    for (int i = 0; i < 4; i++)
    begin
      p = fsie_pkg::SUP_FLAG_POS[i];
      pulse(7'h40 >> i);
      host.rd(8'h0E, d, v);
      chk(d, 16'h1 << p);
      wait_irq(1'h1);
      host.rd(8'h0E, d, v);
      chk(d, 16'h1 << p);
      host.wr(8'h0E, 16'h1 << p);
      host.wr(8'h0E, 16'h1 << (p - 1));
      host.rd(8'h0E, d, v);
      chk(d, 16'h1 << p);
      chk({15'h0, irq}, 16'h0001);
      host.wr(8'h0E, 16'h3 << (p - 1));
      wait_irq(1'h0);
      host.rd(8'h0E, d, v);
      chk(d, 16'h0000);
    end
    $display("test supply faults done");
    // each event gated by its own field, then let through once enabled
    for (int i = 0; i < 3; i++)
    begin
      host.wr(8'h0C, 16'h00FF ^ (16'h2 << 2 * i));
      pulse(7'h1 << i);
      repeat (3) @(posedge sys_clk);
      #1;
      chk({15'h0, irq}, 16'h0000);
      @(posedge sys_clk);
      host.rd(8'h22, d, v);
      chk(d, 16'h1 << 2 * i);
      host.wr(8'h0C, 16'h0003 << 2 * i);
      wait_irq(1'h1);
      host.wr(8'h22, 16'h1 << 2 * i);
      wait_irq(1'h0);
    end
    // led fault with every gate open raises the line
    pulse(7'h01);
    wait_irq(1'h1);
    host.wr(8'h22, 16'h0001);
    wait_irq(1'h0);
    $display("test event gating done");
    // global field off hides a latched supply fault
    host.wr(8'h0C, 16'h007F);
    pulse(7'h40);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({15'h0, irq}, 16'h0000);
    @(posedge sys_clk);
    host.wr(8'h0C, 16'h00C0);
    wait_irq(1'h1);
    // detection during the clearing write keeps the flag
    det <= 7'h40;
    host.wr(8'h0E, 16'hC000);
    det <= '0;
    host.rd(8'h0E, d, v);
    chk(d, 16'h8000);
    host.wr(8'h0E, 16'hC000);
    wait_irq(1'h0);
    $display("test global and set-wins done");
    // second reset in mid-run restores the enable fields
    host.wr(8'h0C, 16'h0055);
    pulse(7'h20);
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    host.rd(8'h0E, d, v);
    chk(d, 16'h0000);
    chk({15'h0, v}, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    @(posedge sys_clk);
    host.rd(8'h0C, d, v);
    chk(d, 16'h00AA);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
